//--- hw/ssw_supervisor.sv
/*
  Supply supervisor with watchdog: top of the block. Produces both
  reset polarities, the power-fail warning and the watchdog output.
  Assumes the analog comparators arrive as digital flags synchronous to
  mclk, and that the host toggles the kick input while it is healthy.

  // Overview of operation
  // - Manual reset input is active low and starts a reset pulse.
  // - Power-fail warning goes low while the comparator reports low voltage.
  // - Kick input constant for the full period sets the watchdog output low.
  // - Kick input left undriven disables the watchdog.
  // - Watchdog count clears on reset, undriven kick, or any kick edge.
  // - Reset output pulses low for the full stretch time when triggered.
  // - Reset stays low for as long as supply low is flagged.
  // - Reset stays low a stretch time after supply or manual release.
  // - Watchdog expiry never drives reset internally.
  // - Watchdog output stays low after expiry until a clear.
  // - Supply low forces watchdog output low, released with no delay.
  // - High reset output is the exact complement of the low one.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssw_consts.svh"

module ssw_supervisor #(
  // stretch and timeout counts, shortenable in simulation
  parameter ssw_pkg::ssw_cnt_t RST_CYC =
    32'(`SSW_MS_CYC(`SSW_T_RST_MS)),
  parameter ssw_pkg::ssw_cnt_t WD_CYC  =
    32'(`SSW_MS_CYC(`SSW_T_WD_MS)),
  // Low: standard threshold flag; high: lower threshold flag
  parameter bit                LOW_THRESH = 1'b0,
  // Watchdog output present
  parameter bit                HAS_WDOG   = 1'b1,
  // Active-low reset output present
  parameter bit                HAS_RST_N  = 1'b1,
  // Active-high reset output present
  parameter bit                HAS_RST_P  = 1'b1
) (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic clk_en,
  // Manual reset, active low
  input  wire logic manual_reset_n,
  // Supply below the standard threshold
  input  wire logic supply_low_std,
  // Supply below the lower threshold
  input  wire logic supply_low_lo,
  // Monitored voltage below its reference
  input  wire logic power_fail_sense_in,
  // Kick level from the host
  input  wire logic watchdog_kick_in,
  // Kick pin is undriven
  input  wire logic watchdog_kick_hiz,
  output logic      reset_out_n,
  output logic      reset_out,
  output logic      power_fail_warn_n,
  output logic      watchdog_expired_n
);
  import ssw_pkg::*;

  // Kick synchroniser and edge stage
  logic kick_s1_reg;
  logic kick_s1_next;
  logic kick_s2_reg;
  logic kick_s2_next;
  logic kick_s3_reg;
  logic kick_s3_next;
  logic kick_edge;

  // Output flops
  logic rst_n_reg;
  logic rst_n_next;
  logic rst_p_reg;
  logic rst_p_next;
  logic pfw_n_reg;
  logic pfw_n_next;
  logic expired_n_reg;
  logic expired_n_next;

  // Internal levels
  logic supply_low;
  logic rst_trig;
  logic rst_act;
  logic wd_expired;

  // threshold variant picks one supply flag
  assign supply_low = LOW_THRESH ? supply_low_lo : supply_low_std;

  // manual reset and supply low both trigger reset
  assign rst_trig = !manual_reset_n || supply_low;

  // Reset stretch timer
  ssw_reset_stretch #(
    .RST_CYC (RST_CYC)
  ) u_stretch (
    .mclk   (mclk),
    .rstn   (rstn),
    .clk_en (clk_en),
    .trig   (rst_trig),
    .active (rst_act)
  );

  // kick synchroniser; first stage feeds only the second
  always_comb begin
    kick_s1_next = watchdog_kick_in;
    kick_s2_next = kick_s1_reg;
    kick_s3_next = kick_s2_reg;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      kick_s1_reg <= 1'b0;
      kick_s2_reg <= 1'b0;
      kick_s3_reg <= 1'b0;
    end else if (clk_en) begin
      kick_s1_reg <= kick_s1_next;
      kick_s2_reg <= kick_s2_next;
      kick_s3_reg <= kick_s3_next;
    end
  end

  // either direction of kick counts as an edge
  assign kick_edge = kick_s2_reg ^ kick_s3_reg;

  // Watchdog timer, cleared while reset is asserted
  ssw_watchdog #(
    .WD_CYC (WD_CYC)
  ) u_wdog (
    .mclk       (mclk),
    .rstn       (rstn),
    .clk_en     (clk_en),
    .kick_edge  (kick_edge),
    .kick_hiz   (watchdog_kick_hiz),
    .rst_active (rst_act),
    .expired    (wd_expired)
  );

  // Absent outputs park at idle once out of reset, one rule shared by all optional pins
  function automatic logic ssw_park(
    input bit   present,
    input logic level,
    input logic idle
  );
    return present ? level : idle;
  endfunction

  // Output next values
  always_comb begin
    // both polarities from the same internal level
    rst_n_next = ssw_park(HAS_RST_N, !rst_act, 1'b1);
    rst_p_next = ssw_park(HAS_RST_P, rst_act, 1'b0);
    // comparator straight through, one flop of delay
    pfw_n_next = !power_fail_sense_in;
    // supply low forces the watchdog output, no stretch
    // expiry reaches only this pin, never the reset path
    expired_n_next = ssw_park(HAS_WDOG, !(wd_expired || supply_low), 1'b1);
  end

  // Outputs come from flops; reset shows reset asserted
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_n_reg <= 1'b0;
      rst_p_reg <= 1'b1;
      pfw_n_reg <= 1'b1;
      expired_n_reg <= 1'b1;
    end else if (clk_en) begin
      rst_n_reg <= rst_n_next;
      rst_p_reg <= rst_p_next;
      pfw_n_reg <= pfw_n_next;
      expired_n_reg <= expired_n_next;
    end
  end

  assign reset_out_n        = rst_n_reg;
  assign reset_out          = rst_p_reg;
  assign power_fail_warn_n  = pfw_n_reg;
  assign watchdog_expired_n = expired_n_reg;

  // Checks on the pins and on internal levels

  property p_manual_asserts;
    @(posedge mclk) disable iff (!rstn)
      clk_en && !manual_reset_n && HAS_RST_N |=> !reset_out_n;
  endproperty
  a_manual_asserts: assert property (p_manual_asserts) // Manual
    else $error("manual reset did not assert reset");

  property p_power_fail;
    @(posedge mclk) disable iff (!rstn)
      clk_en |=> power_fail_warn_n == !$past(power_fail_sense_in);
  endproperty
  a_power_fail: assert property (p_power_fail) // Warning
    else $error("power-fail warning does not follow comparator");

  property p_complement;
    @(posedge mclk) disable iff (!rstn)
      HAS_RST_N && HAS_RST_P |-> reset_out == !reset_out_n;
  endproperty
  a_complement: assert property (p_complement) // Polarity
    else $error("reset outputs are not complements");

  property p_low_line_wd;
    @(posedge mclk) disable iff (!rstn)
      clk_en && supply_low && HAS_WDOG |=> !watchdog_expired_n;
  endproperty
  a_low_line_wd: assert property (p_low_line_wd) // Low line
    else $error("watchdog output high during supply low");

  property p_low_line_release;
    @(posedge mclk) disable iff (!rstn)
      clk_en && !supply_low && !wd_expired |=> watchdog_expired_n;
  endproperty
  a_low_line_release: assert property (p_low_line_release) // Free
    else $error("watchdog output not released after supply ok");

  property p_no_wd_reset;
    @(posedge mclk) disable iff (!rstn)
      clk_en && wd_expired && !rst_act |=> reset_out_n;
  endproperty
  a_no_wd_reset: assert property (p_no_wd_reset) // Isolated
    else $error("watchdog expiry asserted reset internally");

  property p_supply_holds;
    @(posedge mclk) disable iff (!rstn)
      clk_en && supply_low && HAS_RST_N |=> !reset_out_n;
  endproperty
  a_supply_holds: assert property (p_supply_holds) // Supply
    else $error("reset released while supply low");

  property p_kick_edge;
    @(posedge mclk) disable iff (!rstn)
      clk_en && kick_s1_reg != kick_s2_reg ##1 clk_en |-> kick_edge;
  endproperty
  a_kick_edge: assert property (p_kick_edge) // Sync
    else $error("kick edge not seen two cycles after input change");

  // Enable low is a full stall, so no pin may move
  property p_freeze;
    @(posedge mclk) disable iff (!rstn)
      !clk_en |=> $stable(reset_out_n) && $stable(reset_out)
        && $stable(power_fail_warn_n) && $stable(watchdog_expired_n);
  endproperty
  a_freeze: assert property (p_freeze) // Enable
    else $error("outputs moved while clock enable low");

  property p_expiry_pin;
    @(posedge mclk) disable iff (!rstn)
      clk_en && wd_expired && HAS_WDOG |=> !watchdog_expired_n;
  endproperty
  a_expiry_pin: assert property (p_expiry_pin) // Timeout
    else $error("watchdog output high after expiry");

  property p_rst_act_pin;
    @(posedge mclk) disable iff (!rstn)
      clk_en && rst_act && HAS_RST_N |=> !reset_out_n;
  endproperty
  a_rst_act_pin: assert property (p_rst_act_pin) // Pulse
    else $error("reset released during pulse");

  property p_rst_idle_pin;
    @(posedge mclk) disable iff (!rstn)
      clk_en && !rst_act |=> reset_out_n;
  endproperty
  a_rst_idle_pin: assert property (p_rst_idle_pin) // Pulse end
    else $error("reset held after pulse ended");

  // Release of a trigger must not release the pin at once
  property p_trig_stretch;
    @(posedge mclk) disable iff (!rstn)
      clk_en && rst_trig ##1 clk_en && !rst_trig && HAS_RST_N
        |=> !reset_out_n;
  endproperty
  a_trig_stretch: assert property (p_trig_stretch) // Stretch
    else $error("reset released without stretch");

  property p_rst_clears_wd;
    @(posedge mclk) disable iff (!rstn)
      clk_en && rst_act |=> !wd_expired;
  endproperty
  a_rst_clears_wd: assert property (p_rst_clears_wd) // Clear
    else $error("watchdog expired while reset asserted");

  property p_hiz_pin;
    @(posedge mclk) disable iff (!rstn)
      clk_en && watchdog_kick_hiz ##1 clk_en && !supply_low
        |=> watchdog_expired_n;
  endproperty
  a_hiz_pin: assert property (p_hiz_pin) // Off
    else $error("watchdog output low with kick undriven");

  property p_hiz_no_expiry;
    @(posedge mclk) disable iff (!rstn)
      clk_en && watchdog_kick_hiz |=> !wd_expired;
  endproperty
  a_hiz_no_expiry: assert property (p_hiz_no_expiry) // Off
    else $error("watchdog expired with kick undriven");

  property p_rst_high;
    @(posedge mclk) disable iff (!rstn)
      clk_en && rst_act && HAS_RST_P |=> reset_out;
  endproperty
  a_rst_high: assert property (p_rst_high) // High
    else $error("high reset output not asserted");

  property p_power_fail_low;
    @(posedge mclk) disable iff (!rstn)
      clk_en && power_fail_sense_in |=> !power_fail_warn_n;
  endproperty
  a_power_fail_low: assert property (p_power_fail_low) // Low
    else $error("power-fail warning not low");

endmodule
`default_nettype wire

//--- hw/ssw_consts.svh
/*
  Timing figures and counts for the supply supervisor and watchdog.
  Assumes the core clock runs at the rate given here.
*/
`ifndef SSW_CONSTS_SVH
`define SSW_CONSTS_SVH

// Core clock rate in MHz
`define SSW_CLK_MHZ      250
// Reset stretch time in ms
`define SSW_T_RST_MS     200
// Watchdog timeout period in ms
`define SSW_T_WD_MS      1600
// Cycles for a time in ms at the core clock rate
`define SSW_MS_CYC(ms)   ((ms) * `SSW_CLK_MHZ * 1000)
// Counter reset value
`define SSW_CNT_ZERO     32'h0
// Counter step
`define SSW_CNT_ONE      32'h1

`endif

//--- hw/ssw_pkg.sv
/*
  Types shared by the supply supervisor and watchdog modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ssw_pkg;

  // Counter word for the long timers
  typedef logic [31:0] ssw_cnt_t;

  // Reset stretch states, one-hot
  typedef enum logic [2:0] {
    SSW_ST_IDLE    = 3'b001,
    SSW_ST_HOLD    = 3'b010,
    SSW_ST_STRETCH = 3'b100
  } ssw_rst_state_e;

endpackage

//--- hw/ssw_reset_stretch.sv
/*
  Reset stretcher: holds reset while the trigger is high, then for a
  further RST_CYC cycles. Comes out of its own reset stretching.
  Assumes the trigger is synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssw_consts.svh"

module ssw_reset_stretch #(
  parameter ssw_pkg::ssw_cnt_t RST_CYC = 32'(`SSW_MS_CYC(`SSW_T_RST_MS))
) (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic clk_en,
  input  wire logic trig,
  output logic      active
);
  import ssw_pkg::*;

  ssw_rst_state_e state_reg;
  ssw_rst_state_e state_next;
  ssw_cnt_t       cnt_reg;
  ssw_cnt_t       cnt_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      SSW_ST_IDLE: begin
        if (trig) begin
          state_next = SSW_ST_HOLD;
        end
      end
      SSW_ST_HOLD: begin
        cnt_next = `SSW_CNT_ZERO;
        if (!trig) begin
          state_next = SSW_ST_STRETCH;
        end
      end
      SSW_ST_STRETCH: begin
        if (trig) begin
          state_next = SSW_ST_HOLD;
          cnt_next   = `SSW_CNT_ZERO;
        end else if (cnt_reg == RST_CYC - `SSW_CNT_ONE) begin
          state_next = SSW_ST_IDLE;
          cnt_next   = `SSW_CNT_ZERO;
        end else begin
          cnt_next = cnt_reg + `SSW_CNT_ONE;
        end
      end
    endcase
  end

  // Power-up counts as a trigger, so reset leaves us stretching
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= SSW_ST_STRETCH;
      cnt_reg   <= `SSW_CNT_ZERO;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign active = trig || (state_reg != SSW_ST_IDLE);

  property p_hold_on_trig;
    @(posedge mclk) disable iff (!rstn)
      clk_en && trig |=> state_reg == SSW_ST_HOLD;
  endproperty
  a_hold_on_trig: assert property (p_hold_on_trig) // Hold
    else $error("reset not held while triggered");

  property p_stretch_start;
    @(posedge mclk) disable iff (!rstn)
      clk_en && !trig && state_reg == SSW_ST_HOLD
        |=> state_reg == SSW_ST_STRETCH && cnt_reg == `SSW_CNT_ZERO;
  endproperty
  a_stretch_start: assert property (p_stretch_start) // Start
    else $error("stretch did not start on release");

  property p_stretch_end;
    @(posedge mclk) disable iff (!rstn)
      clk_en && !trig && state_reg == SSW_ST_STRETCH
        && cnt_reg == RST_CYC - `SSW_CNT_ONE
        |=> state_reg == SSW_ST_IDLE;
  endproperty
  a_stretch_end: assert property (p_stretch_end) // Length
    else $error("stretch did not end at full count");

endmodule
`default_nettype wire

//--- hw/ssw_watchdog.sv
/*
  Watchdog timer: counts cycles without a kick edge and flags expiry
  at WD_CYC. Any clear condition empties the count and drops the flag.
  Assumes edge, undriven flag and reset level are synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssw_consts.svh"

module ssw_watchdog #(
  parameter ssw_pkg::ssw_cnt_t WD_CYC = 32'(`SSW_MS_CYC(`SSW_T_WD_MS))
) (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic clk_en,
  input  wire logic kick_edge,
  input  wire logic kick_hiz,
  input  wire logic rst_active,
  output logic      expired
);
  import ssw_pkg::*;

  ssw_cnt_t cnt_reg;
  ssw_cnt_t cnt_next;
  logic     exp_reg;
  logic     exp_next;
  logic     clr;

  assign clr = kick_edge || kick_hiz || rst_active;

  // timeout count; flag stays until cleared
  always_comb begin
    cnt_next = cnt_reg;
    exp_next = exp_reg;
    if (clr) begin
      cnt_next = `SSW_CNT_ZERO;
      exp_next = 1'b0;
    end else if (cnt_reg == WD_CYC - `SSW_CNT_ONE) begin
      exp_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + `SSW_CNT_ONE;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= `SSW_CNT_ZERO;
      exp_reg <= 1'b0;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
      exp_reg <= exp_next;
    end
  end

  assign expired = exp_reg;

  property p_timeout;
    @(posedge mclk) disable iff (!rstn)
      clk_en && !clr && cnt_reg == WD_CYC - `SSW_CNT_ONE |=> exp_reg;
  endproperty
  a_timeout: assert property (p_timeout) // Expiry
    else $error("watchdog did not expire at full count");

  property p_no_early;
    @(posedge mclk) disable iff (!rstn)
      clk_en && !exp_reg && cnt_reg != WD_CYC - `SSW_CNT_ONE |=> !exp_reg;
  endproperty
  a_no_early: assert property (p_no_early) // Early
    else $error("watchdog expired before full count");

  property p_edge_clears;
    @(posedge mclk) disable iff (!rstn)
      clk_en && kick_edge |=> cnt_reg == `SSW_CNT_ZERO && !exp_reg;
  endproperty
  a_edge_clears: assert property (p_edge_clears) // Kick
    else $error("kick edge did not clear watchdog");

  property p_hiz_off;
    @(posedge mclk) disable iff (!rstn)
      clk_en && kick_hiz [*2] |-> cnt_reg == `SSW_CNT_ZERO && !exp_reg;
  endproperty
  a_hiz_off: assert property (p_hiz_off) // Disabled
    else $error("watchdog ran with kick undriven");

  property p_sticky;
    @(posedge mclk) disable iff (!rstn)
      clk_en && exp_reg && !clr |=> exp_reg;
  endproperty
  a_sticky: assert property (p_sticky) // Sticky
    else $error("expiry dropped without a clear");

endmodule
`default_nettype wire

//--- testbench/ssw_host_model.sv
/*
  Host processor model: kicks the watchdog input and obeys reset.
  Assumes mclk from the bench; moves its pins 1 ns after an edge.
*/
`timescale 1ns/1ps
`default_nettype none

module ssw_host_model (
  input  wire logic       mclk,
  input  wire logic       reset_in_n,
  input  wire logic       kick_en,
  input  wire logic       float_en,
  input  wire logic       toggle_req,
  input  wire logic [7:0] kick_gap,
  output logic            kick_out,
  output logic            kick_hiz
);
  int   gap_cnt = 0;
  logic do_tog;
  logic float_s;
  logic float_d   = 1'h0;
  logic kick_q    = 1'h0;
  logic hiz_q     = 1'h0;

  // Pins driven from one process only
  assign kick_out = kick_q;
  assign kick_hiz = hiz_q;

  // Requests sampled at the edge, pins moved just after it
  always @(posedge mclk) begin
    do_tog = toggle_req;
    float_s = float_en;
    gap_cnt = gap_cnt + 1;
    if (kick_en && reset_in_n && gap_cnt >= kick_gap) begin
      do_tog = 1'h1;
      gap_cnt = 0;
    end
    #1;
    // released pin has no pull: it flips once, then holds still
    hiz_q = float_s;
    if ((float_s && !float_d) || do_tog) begin
      kick_q = ~kick_q;
    end
    float_d = float_s;
  end
endmodule

`default_nettype wire

//--- testbench/ssw_supervisor_tb.sv
/*
  Self-checking bench for the supervisor with shortened timers.
  Assumes the host model drives the kick pin and hi-z flag.
*/
`timescale 1ns/1ps
`default_nettype none

module ssw_supervisor_tb;
  localparam int RC = 20;
  localparam int WC = 50;

  logic mclk                = 1'h0;
  logic rstn                = 1'h0;
  logic clk_en              = 1'h1;
  logic manual_reset_n      = 1'h1;
  logic supply_low_std      = 1'h0;
  logic supply_low_lo       = 1'h0;
  logic power_fail_sense_in = 1'h0;
  logic kick_en             = 1'h1;
  logic float_en            = 1'h0;
  logic toggle_req          = 1'h0;
  logic kick;
  logic kick_hiz;
  logic reset_out_n;
  logic reset_out;
  logic power_fail_warn_n;
  logic watchdog_expired_n;
  int   bad_count           = 0;
  int   comparisons         = 0;

  // 250 MHz core clock
  always #2 mclk = ~mclk;

  // Standard threshold and all outputs present come from the defaults
  ssw_supervisor #(
    .RST_CYC (32'h14),
    .WD_CYC  (32'h32)
  ) ssw_supervisor_inst (
    .mclk                (mclk),
    .rstn                (rstn),
    .clk_en              (clk_en),
    .manual_reset_n      (manual_reset_n),
    .supply_low_std      (supply_low_std),
    .supply_low_lo       (supply_low_lo),
    .power_fail_sense_in (power_fail_sense_in),
    .watchdog_kick_in    (kick),
    .watchdog_kick_hiz   (kick_hiz),
    .reset_out_n         (reset_out_n),
    .reset_out           (reset_out),
    .power_fail_warn_n   (power_fail_warn_n),
    .watchdog_expired_n  (watchdog_expired_n)
  );

  // Kick gap near the timeout to stress the margin
  ssw_host_model ssw_host_model_inst (
    .mclk       (mclk),
    .reset_in_n (reset_out_n),
    .kick_en    (kick_en),
    .float_en   (float_en),
    .toggle_req (toggle_req),
    .kick_gap   (8'h28),
    .kick_out   (kick),
    .kick_hiz   (kick_hiz)
  );

  task automatic final_report();
    $display("counts: %0d compared, %0d wrong", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Inputs move 1 ns after the edge, away from sampling
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic check_bit(input logic got, input logic exp,
                           input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic check_range(input int got, input int lo, input int hi,
                             input string what);
    comparisons++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("wrong value at %0t: %s took %0d", $time, what, got);
    end
  endtask

  // Bounded wait for reset release, watching both polarities
  task automatic wait_rst(output int n);
    n = 0;
    while (reset_out_n !== 1'h1 && n < 400) begin
      check_bit(reset_out, ~reset_out_n, "reset complement");
      tick();
      n++;
    end
    if (n >= 400) begin
      bad_count++;
      $display("wrong value at %0t: reset never released", $time);
      final_report();
    end
    check_bit(reset_out, 1'h0, "reset high released");
  endtask

  task automatic wait_wd(input logic v, output int n);
    n = 0;
    while (watchdog_expired_n !== v && n < 400) begin
      tick();
      n++;
    end
    if (n >= 400) begin
      bad_count++;
      $display("wrong value at %0t: watchdog wait ran out", $time);
      final_report();
    end
  endtask

  task automatic hold_wd(input int cycles);
    repeat (cycles) begin
      tick();
      check_bit(watchdog_expired_n, 1'h1, "watchdog fired");
    end
  endtask

  task automatic t_por();
    int n;
    check_bit(reset_out_n, 1'h0, "power-up reset");
    wait_rst(n);
    check_range(n, RC, RC + 3, "power-up stretch");
    $display("test power-up done");
  endtask

  // One-cycle pulse, warning checked low then released on the next cycle
  task automatic t_pfail();
    power_fail_sense_in = 1'h1;
    tick();
    power_fail_sense_in = 1'h0;
    check_bit(power_fail_warn_n, 1'h0, "warn not low");
    tick();
    check_bit(power_fail_warn_n, 1'h1, "warn not released");
    $display("test power fail done");
  endtask

  // Enable low must freeze outputs even with triggers present
  task automatic t_freeze();
    clk_en = 1'h0;
    manual_reset_n = 1'h0;
    power_fail_sense_in = 1'h1;
    repeat (4) tick();
    check_bit(reset_out_n, 1'h1, "reset moved while frozen");
    check_bit(power_fail_warn_n, 1'h1, "warn moved while frozen");
    manual_reset_n = 1'h1;
    power_fail_sense_in = 1'h0;
    clk_en = 1'h1;
    tick();
    check_bit(reset_out_n, 1'h1, "frozen trigger replayed");
    check_bit(power_fail_warn_n, 1'h1, "frozen warn replayed");
    $display("test clock enable done");
  endtask

  task automatic t_manual();
    int n;
    manual_reset_n = 1'h0;
    tick();
    manual_reset_n = 1'h1;
    check_bit(reset_out_n, 1'h0, "manual reset ignored");
    wait_rst(n);
    check_range(n, RC, RC + 4, "manual stretch");
    $display("test manual reset done");
  endtask

  task automatic t_supply();
    int n;
    supply_low_lo = 1'h1;
    repeat (30) tick();
    check_bit(reset_out_n, 1'h1, "unselected flag used");
    supply_low_lo = 1'h0;
    supply_low_std = 1'h1;
    tick();
    tick();
    check_bit(watchdog_expired_n, 1'h0, "low line watchdog");
    repeat (30) tick();
    check_bit(reset_out_n, 1'h0, "reset not held");
    supply_low_std = 1'h0;
    tick();
    check_bit(watchdog_expired_n, 1'h1, "watchdog release late");
    check_bit(reset_out_n, 1'h0, "stretch skipped");
    wait_rst(n);
    check_range(n, RC, RC + 3, "supply stretch");
    $display("test supply low done");
  endtask

  task automatic kick_once();
    toggle_req = 1'h1;
    tick();
    toggle_req = 1'h0;
  endtask

  task automatic t_expire();
    int n;
    kick_en = 1'h0;
    kick_once();
    wait_wd(1'h0, n);
    check_range(n, WC + 1, WC + 9, "timeout period");
    repeat (20) tick();
    check_bit(watchdog_expired_n, 1'h0, "expiry not held");
    check_bit(reset_out_n, 1'h1, "expiry reset");
    kick_once();
    wait_wd(1'h1, n);
    check_range(n, 1, 7, "kick clear");
    $display("test watchdog expiry done");
  endtask

  task automatic t_kick();
    kick_en = 1'h1;
    hold_wd(4 * WC);
    $display("test kicking done");
  endtask

  // Pin flipping once as it goes undriven must not matter
  task automatic t_hiz();
    kick_en = 1'h0;
    float_en = 1'h1;
    hold_wd(3 * WC);
    float_en = 1'h0;
    $display("test undriven kick done");
  endtask

  // Count runs from the end of the stretch, not from the kick
  task automatic t_rstclr();
    int n;
    kick_once();
    repeat (30) tick();
    manual_reset_n = 1'h0;
    tick();
    manual_reset_n = 1'h1;
    wait_wd(1'h0, n);
    check_range(n, RC + WC, RC + WC + 10, "reset clear");
    check_bit(reset_out_n, 1'h1, "expiry reset");
    kick_once();
    $display("test reset clear done");
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    #1;
    rstn = 1'h1;
    t_por();
    t_pfail();
    t_freeze();
    t_manual();
    t_supply();
    t_expire();
    t_kick();
    t_hiz();
    t_rstclr();
    final_report();
  end
endmodule

`default_nettype wire
